// >>> bench/host_port.sv
// host serial port model: makes the link clock in slave operation and gathers bits
// assumes the bench feeds it the resolved clock pin, the data pin and the marker pin
`timescale 1ns/100ps
module host_port (
  input wire logic sclk,
  input wire logic sdata,
  input wire logic marker,
  input wire logic pol,
  output logic host_clk,
  output logic cs_n,
  output logic rd_n
);
  logic [19:0] word;
  int count;
  initial begin
    host_clk = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    word = 20'h0;
    count = 0;
  end
  // master frames: a bit is taken on each clock rise while the marker is active
  always @(posedge sclk) begin
    if (marker != pol) begin
      word = {word[18:0], sdata};
      count++;
    end
  end
  // select and read strobe move together; the link clock is parked first so no stray edge
  task automatic select(input logic v, input logic idle_clk);
    #20;
    host_clk = idle_clk;
    cs_n = v;
    rd_n = v;
    word = 20'h0;
    count = 0;
  endtask
  // slave frames: 800 ns period, long active phase so a late update settles before sampling
  task automatic clock_frame(input logic inv, input int edges);
    #37;
    word = {19'h0, sdata};
    for (int i = 0; i < edges; i++) begin
      host_clk = !inv;
      #500;
      word = {word[18:0], sdata};
      host_clk = inv;
      #300;
    end
  endtask
endmodule

// >>> bench/tb_result_port.sv
// self-checking bench for the result port: registers, parallel pins, serial master and slave, read error
// assumes host_port beside it; the shared clock pin is resolved here from the port's bit 11 output enable alone
`timescale 1ns/100ps
`include "serial_port_defs.svh"
module tb_result_port;
  import serial_port_pkg::*;
  logic hclk, hresetn, hsel, hwrite, conv_start, conv_done, hreadyout, hresp, irq, busy;
  logic src, inv, pol, coding, chain, d10, d11, d11_oe_n, d12, d13, port_oe_n, host_clk, cs_n, rd_n;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, mode;
  logic [17:0] conv_result;
  logic [3:0] high_bits;
  int bad_count, cmp_count, cycles;
  wire logic sclk = d11_oe_n ? host_clk : d11;
  result_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .irq(irq), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .busy(busy), .mode(mode), .cs_n(cs_n), .rd_n(rd_n),
    .clock_source_select(src), .clock_invert_select(inv), .marker_polarity_select(pol),
    .output_coding_select(coding), .read_mode_or_chain_input(chain), .result_bit_ten(d10),
    .result_bit_eleven_in(sclk), .result_bit_eleven_out(d11), .result_bit_eleven_oe_n(d11_oe_n),
    .result_bit_twelve(d12), .result_bit_thirteen(d13), .result_high_bits(high_bits), .port_oe_n(port_oe_n));
  host_port host (.sclk(sclk), .sdata(d10), .marker(d12), .pol(pol), .host_clk(host_clk),
    .cs_n(cs_n), .rd_n(rd_n));
  // 10 MHz bus clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = !hclk;
  end
  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single AHB-Lite transfer; read data taken at the edge that ends the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic [17:0] code(input logic [17:0] v);
    return coding ? v : v ^ 18'h20000;
  endfunction
  // returns right after the done pulse, so a following error pulse is seen from its start
  task automatic convert(input logic [17:0] v);
    @(posedge hclk);
    conv_start <= 1'b1;
    @(posedge hclk);
    conv_start <= 1'b0;
    cyc(3);
    chk(busy, 32'h1);
    conv_done <= 1'b1;
    conv_result <= v;
    @(posedge hclk);
    conv_done <= 1'b0;
  endtask
  task automatic t_regs;
    logic [31:0] r;
    ahb(1'b0, `OFS_CTRL, 32'h0, r);
    chk(r, `CTRL_RESET);
    chk({hreadyout, hresp}, 2'b10);
    ahb(1'b0, `OFS_MASK, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b1, `OFS_MASK, 32'h5, r);
    ahb(1'b0, `OFS_MASK, 32'h0, r);
    chk(r, 32'h5);
    ahb(1'b1, 8'h40, 32'hffff_ffff, r);
    ahb(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0);
  endtask
  // both codings on the parallel pins; bit 11 pin must be driving
  task automatic t_parallel;
    logic [17:0] e;
    logic [31:0] r;
    for (int k = 0; k < 2; k++) begin
      mode <= 2'h0;
      coding <= k[0];
      convert(18'h2a5c3);
      cyc(6);
      e = code(18'h2a5c3);
      chk(busy, 32'h0);
      chk({high_bits, d13, d12, d11, d10, d11_oe_n}, {e[17:10], 1'b0});
      ahb(1'b0, `OFS_RESULT, 32'h0, r);
      chk(r, {14'h0, e});
    end
  endtask
  // p high: read mode high, so the frame runs while the next conversion is busy, with doubled quarters
  task automatic t_master(input logic p);
    logic [17:0] e;
    logic [31:0] r;
    mode <= 2'h3;
    src <= 1'b0;
    inv <= 1'b0;
    pol <= p;
    chain <= p;
    ahb(1'b1, `OFS_CTRL, p ? 32'h2 : 32'h1, r);
    convert(18'h1c3a5 ^ {17'h0, p});
    e = code(18'h1c3a5 ^ {17'h0, p});
    if (p) begin
      conv_start <= 1'b1;
      @(posedge hclk);
      conv_start <= 1'b0;
    end
    cyc(6);
    chk(d12, p);
    host.select(1'b0, 1'b0);
    cyc(20);
    chk({d11_oe_n, port_oe_n, d12}, {2'b00, !p});
    for (int i = 0; i < 200 && host.count < 18; i++) @(posedge hclk);
    cyc(8);
    chk(host.count, 18);
    chk(host.word[17:0], e);
    chk({d12, d13}, {p, 1'b0});
    ahb(1'b0, `OFS_STATE, 32'h0, r);
    chk(r, {27'h0, 1'b0, p, 2'h2, 1'b1});
    host.select(1'b1, 1'b0);
    cyc(6);
    chk(port_oe_n, 32'h1);
  endtask
  task automatic t_slave(input logic i);
    logic [17:0] e;
    mode <= 2'h3;
    src <= 1'b1;
    inv <= i;
    pol <= 1'b0;
    chain <= !i;
    convert(18'h2b6d1);
    e = code(18'h2b6d1);
    host.select(1'b0, i);
    cyc(8);
    chk(d11_oe_n, 32'h1);
    host.clock_frame(i, 18);
    chk(host.word[18:0], {e, !i});
    chk({d12, d13}, 2'b00);
    host.select(1'b1, i);
    cyc(6);
  endtask
  // a conversion ends five bits into a slave read: flag pulse, sticky status, masked interrupt
  task automatic t_error;
    logic [31:0] r;
    int n;
    inv <= 1'b0;
    ahb(1'b0, `OFS_STATUS, 32'h0, r);
    chk(r & 32'h4, 32'h4);
    ahb(1'b1, `OFS_STATUS, 32'h7, r);
    ahb(1'b1, `OFS_MASK, 32'h2, r);
    convert(18'h15555);
    host.select(1'b0, 1'b0);
    cyc(8);
    host.clock_frame(1'b0, 5);
    chk({d13, irq}, 2'b00);
    convert(18'h0aaaa);
    for (int i = 0; i < 20 && d13 !== 1'b1; i++) @(posedge hclk);
    n = 0;
    while (d13 === 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk(n, `ERR_PULSE_NS / `CLK_PERIOD_NS);
    chk(irq, 32'h1);
    ahb(1'b0, `OFS_STATUS, 32'h0, r);
    chk(r & 32'h6, 32'h2);
    ahb(1'b1, `OFS_STATUS, 32'h2, r);
    cyc(2);
    chk({irq, d13}, 2'b00);
    host.select(1'b1, 1'b0);
    cyc(6);
  endtask
  initial begin
    {hresetn, hsel, hwrite, conv_start, conv_done, src, inv, pol, chain} = 9'h0;
    {haddr, hwdata, htrans, mode, conv_result} = 86'h0;
    coding = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_parallel;
    t_master(1'b0);
    t_master(1'b1);
    t_slave(1'b0);
    t_slave(1'b1);
    t_error;
    report_and_stop;
  end
endmodule

// >>> verilog/result_port.sv
// result port of the converter: parallel bits, serial output, AHB-Lite registers, interrupt
// assumes hclk 10 MHz; conversion engine pulses on hclk; pins arrive asynchronous
`timescale 1ns/100ps
`include "serial_port_defs.svh"
module result_port
  import serial_port_pkg::*;
#(
  parameter int ERR_NS = `ERR_PULSE_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [17:0] conv_result,
  output logic busy,
  input wire logic [1:0] mode,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic clock_source_select,
  input wire logic clock_invert_select,
  input wire logic marker_polarity_select,
  input wire logic output_coding_select,
  input wire logic read_mode_or_chain_input,
  output logic result_bit_ten,
  input wire logic result_bit_eleven_in,
  output logic result_bit_eleven_out,
  output logic result_bit_eleven_oe_n,
  output logic result_bit_twelve,
  output logic result_bit_thirteen,
  output logic [3:0] result_high_bits,
  output logic port_oe_n
);
  localparam int ERR_CYCLES = (ERR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [7:0] ERR_LOAD = 8'(ERR_CYCLES);

  // two flops on every pin input; the third sclk stage only feeds edge detection
  logic [10:0] pins_s1_reg, pins_s2_reg;
  logic sclk_s3_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // reset image reads deselected and parallel, so the clock pin never turns round while pins settle
      pins_s1_reg <= 11'h600;
      pins_s2_reg <= 11'h600;
      sclk_s3_reg <= 1'b0;
    end else begin
      pins_s1_reg <= {cs_n, rd_n, mode, clock_source_select, clock_invert_select, marker_polarity_select,
                      output_coding_select, read_mode_or_chain_input, result_bit_eleven_in, 1'b0};
      pins_s2_reg <= pins_s1_reg;
      sclk_s3_reg <= pins_s2_reg[1];
    end
  end
  logic cs_s, enable, serial, ext, inv, pol, coding, chain_s, sclk_s, master, slave;
  logic sclk_rise, sclk_fall, active_edge;
  assign cs_s = pins_s2_reg[10];
  assign enable = !pins_s2_reg[10] && !pins_s2_reg[9];
  assign serial = pins_s2_reg[8:7] == `SERIAL_MODE;
  assign ext = pins_s2_reg[6];
  assign inv = pins_s2_reg[5];
  assign pol = pins_s2_reg[4];
  assign coding = pins_s2_reg[3];
  assign chain_s = pins_s2_reg[2];
  assign sclk_s = pins_s2_reg[1];
  assign master = serial && !ext;
  assign slave = serial && ext;
  // chip select gates the host clock, so edges while deselected are ignored
  assign sclk_rise = sclk_s && !sclk_s3_reg && !cs_s;
  assign sclk_fall = !sclk_s && sclk_s3_reg && !cs_s;
  assign active_edge = inv ? sclk_fall : sclk_rise;

  // bus and interrupt state
  logic [31:0] ctrl_reg, ctrl_next, hrdata_next;
  logic [`EV_BITS-1:0] status_reg, status_next, mask_reg, mask_next, events;
  logic [7:0] addr_reg, addr_next;
  logic wr_reg, wr_next, irq_next;
  // converter and frame state
  frame_state_t state_reg, state_next;
  logic [17:0] result_reg, result_next, shift_reg, shift_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] qcnt_reg, qcnt_next, err_cnt_reg, err_cnt_next, div_m1;
  logic [1:0] quarter_reg, quarter_next;
  logic busy_next, unread_reg, unread_next, frame_start, loss;
  logic d10_next, d11_next, d11_oe_n_next, d12_next, d13_next, sclk_int;

  // address phase is sampled; read data is prepared then so the slave never waits
  always_comb begin
    addr_next = addr_reg;
    wr_next = 1'b0;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    status_next = status_reg;
    hrdata_next = hrdata;
    if (wr_reg) begin
      if (addr_reg == `OFS_CTRL) begin
        ctrl_next = hwdata;
      end else if (addr_reg == `OFS_STATUS) begin
        status_next = status_reg & ~hwdata[`EV_BITS-1:0];
      end else if (addr_reg == `OFS_MASK) begin
        mask_next = hwdata[`EV_BITS-1:0];
      end
    end
    // a new event beats a clear in the same cycle
    status_next = status_next | events;
    if (hsel && hready && htrans[1]) begin
      addr_next = haddr[7:0];
      wr_next = hwrite;
      if (haddr[7:0] == `OFS_CTRL) begin
        hrdata_next = ctrl_reg;
      end else if (haddr[7:0] == `OFS_STATUS) begin
        hrdata_next = {29'h0, status_reg};
      end else if (haddr[7:0] == `OFS_MASK) begin
        hrdata_next = {29'h0, mask_reg};
      end else if (haddr[7:0] == `OFS_RESULT) begin
        hrdata_next = {14'h0, result_reg};
      end else if (haddr[7:0] == `OFS_STATE) begin
        hrdata_next = {27'h0, unread_reg, busy, state_reg, master};
      end else begin
        hrdata_next = 32'h0;
      end
    end
    irq_next = |(status_next & mask_next);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= 8'h0;
      wr_reg <= 1'b0;
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= 3'h0;
      status_reg <= 3'h0;
      hrdata <= 32'h0;
      irq <= 1'b0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      status_reg <= status_next;
      hrdata <= hrdata_next;
      irq <= irq_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // quarter length comes from software; zero is treated as one cycle
  assign div_m1 = (ctrl_reg[7:0] == 8'h0) ? 8'h0 : ctrl_reg[7:0] - 8'h1;
  // internal clock is high in quarters one and two, data moves in quarter zero
  assign sclk_int = (state_reg == ST_SHIFT) && master && (quarter_reg == 2'h1 || quarter_reg == 2'h2);
  // with read mode high a read may run during the next conversion
  assign frame_start = (state_reg == ST_IDLE) && enable && serial &&
                       (ext || (unread_reg && (!busy || chain_s)));
  assign loss = slave && conv_done && (state_reg == ST_SHIFT);
  assign events = {state_next == ST_DONE && state_reg == ST_SHIFT && !loss, loss, conv_done};

  always_comb begin
    state_next = state_reg;
    result_next = result_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    qcnt_next = qcnt_reg;
    quarter_next = quarter_reg;
    unread_next = unread_reg;
    busy_next = busy;
    err_cnt_next = (err_cnt_reg != 8'h0) ? err_cnt_reg - 8'h1 : 8'h0;
    if (conv_start) begin
      busy_next = 1'b1;
    end
    if (conv_done) begin
      result_next = {conv_result[17] ^ ~coding, conv_result[16:0]};
      unread_next = 1'b1;
      busy_next = 1'b0;
    end
    case (state_reg)
      ST_IDLE: begin
        if (frame_start) begin
          shift_next = result_reg;
          bit_cnt_next = 5'h0;
          qcnt_next = 8'h0;
          quarter_next = 2'h0;
          unread_next = conv_done;
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!serial) begin
          state_next = ST_IDLE;
        end else if (loss) begin
          state_next = ST_DONE;
          err_cnt_next = ERR_LOAD;
        end else if (master) begin
          if (qcnt_reg == div_m1) begin
            qcnt_next = 8'h0;
            quarter_next = quarter_reg + 2'h1;
            if (quarter_reg == 2'h3) begin
              shift_next = {shift_reg[16:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + 5'h1;
              if (bit_cnt_reg == `FRAME_LAST) begin
                state_next = ST_DONE;
              end
            end
          end else begin
            qcnt_next = qcnt_reg + 8'h1;
          end
        end else if (active_edge) begin
          shift_next = {shift_reg[16:0], chain_s};
          bit_cnt_next = bit_cnt_reg + 5'h1;
          if (bit_cnt_reg == `FRAME_LAST) begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        if (slave && active_edge) begin
          shift_next = {shift_reg[16:0], chain_s};
        end
        if (!enable || !serial) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // shared pins fall back to parallel result bits outside serial mode
    d10_next = serial ? shift_reg[17] : result_reg[10];
    d11_next = serial ? (master && (sclk_int ^ inv)) : result_reg[11];
    d11_oe_n_next = slave;
    d12_next = serial ? (master && ((state_reg == ST_SHIFT) ^ pol)) : result_reg[12];
    d13_next = serial ? (slave && err_cnt_reg != 8'h0) : result_reg[13];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      result_reg <= 18'h0;
      shift_reg <= 18'h0;
      bit_cnt_reg <= 5'h0;
      qcnt_reg <= 8'h0;
      quarter_reg <= 2'h0;
      unread_reg <= 1'b0;
      err_cnt_reg <= 8'h0;
      busy <= 1'b0;
      result_bit_ten <= 1'b0;
      result_bit_eleven_out <= 1'b0;
      result_bit_eleven_oe_n <= 1'b0;
      result_bit_twelve <= 1'b0;
      result_bit_thirteen <= 1'b0;
      result_high_bits <= 4'h0;
      port_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
      result_reg <= result_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      qcnt_reg <= qcnt_next;
      quarter_reg <= quarter_next;
      unread_reg <= unread_next;
      err_cnt_reg <= err_cnt_next;
      busy <= busy_next;
      result_bit_ten <= d10_next;
      result_bit_eleven_out <= d11_next;
      result_bit_eleven_oe_n <= d11_oe_n_next;
      result_bit_twelve <= d12_next;
      result_bit_thirteen <= d13_next;
      result_high_bits <= result_reg[17:14];
      port_oe_n <= !enable;
    end
  end

  // checks on the port behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_parallel_shared_bits: assert property (!serial |=> result_bit_ten == $past(result_reg[10]) &&
    result_bit_thirteen == $past(result_reg[13])) else $error("shared pin not parallel bit");
  a_high_bits_out: assert property (##1 result_high_bits == $past(result_reg[17:14]))
    else $error("high result bits not driven");
  a_load_msb_first: assert property (frame_start |=> shift_reg == $past(result_reg) ##1
    (!serial || result_bit_ten == $past(shift_reg[17]))) else $error("frame did not start with msb");
  a_output_coding: assert property (conv_done |=> result_reg[17] == $past(conv_result[17] ^ ~coding))
    else $error("result coding wrong");
  a_master_data_stable: assert property ($past(master && state_reg == ST_SHIFT) && master &&
    $changed(result_bit_eleven_out) |-> $stable(result_bit_ten)) else $error("data moved on clock edge");
  a_slave_shift_edge: assert property (slave && state_reg == ST_SHIFT && !conv_done &&
    !active_edge |=> $stable(shift_reg)) else $error("slave shifted without active edge");
  a_clock_direction: assert property (serial |=> result_bit_eleven_oe_n == $past(ext))
    else $error("clock pin direction wrong");
  a_marker_level: assert property (master |=> result_bit_twelve == $past((state_reg == ST_SHIFT) ^ pol))
    else $error("frame marker level wrong");
  a_error_only_slave: assert property (master |=> !result_bit_thirteen)
    else $error("error flag outside slave operation");
  a_error_pulse: assert property (loss |=> (state_reg == ST_DONE) ##1 result_bit_thirteen [*8])
    else $error("incomplete read not flagged");
  a_chain_bit_in: assert property (slave && state_reg != ST_IDLE && active_edge && !loss |=>
    shift_reg[0] == $past(chain_s)) else $error("chain input not shifted in");
  a_port_enable: assert property (##1 port_oe_n == $past(!enable))
    else $error("port enable wrong");
  a_busy_falls: assert property (conv_done |=> !busy)
    else $error("busy not cleared after latch");
  a_busy_rises: assert property (conv_start && !conv_done |=> busy)
    else $error("busy not raised at conversion start");
  a_error_stays_low: assert property (slave && err_cnt_reg == 8'h0 |=> !result_bit_thirteen)
    else $error("error flag high outside an incomplete read");
  a_irq_level: assert property (##1 irq == |($past(status_next & mask_next)))
    else $error("interrupt level wrong");
  c_master_frame: cover property (master && state_reg == ST_SHIFT ##1 state_reg == ST_DONE);
  c_slave_frame: cover property (slave && state_reg == ST_SHIFT && !loss ##1 state_reg == ST_DONE);
  c_read_error: cover property (loss);
  c_irq_raised: cover property (!irq ##1 irq);
  c_read_during_busy: cover property (master && busy && frame_start);
endmodule

// >>> verilog/serial_port_defs.svh
// constants for the converter result port: bus offsets, pin mode codes, timing
// assumes it is included by the result port package and the result port module
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_RESULT 8'h0c
`define OFS_STATE 8'h10
`define CTRL_RESET 32'h0000_0001
`define SERIAL_MODE 2'h3
`define RESULT_BITS 18
`define FRAME_LAST 5'h11
`define FRAME_FULL 5'h12
`define EV_CONV 0
`define EV_ERROR 1
`define EV_FRAME 2
`define EV_BITS 3
`define ERR_PULSE_NS 1600
`define CLK_PERIOD_NS 100
`endif

// >>> verilog/serial_port_pkg.sv
// types shared by the converter result port
// assumes the constants header sits beside it
`include "serial_port_defs.svh"
package serial_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b10
  } frame_state_t;
endpackage
